// ==== apc_defs.svh ====
`ifndef APC_DEFS_SVH
`define APC_DEFS_SVH
// Register byte offsets
`define APC_OFF_CFG 8'h00
`define APC_OFF_SMOOTH 8'h04
`define APC_OFF_MAXREV 8'h08
`define APC_OFF_CTRL 8'h0c
`define APC_OFF_FMAP_LO 8'h10
`define APC_OFF_FMAP_HI 8'h14
`define APC_OFF_STAT 8'h18
`define APC_OFF_POS 8'h1c
// Field positions
`define APC_CFG_X_LSB 0
`define APC_CFG_Y_LSB 4
`define APC_CTRL_PT_BIT 0
// Reset values
`define APC_RST_CFG 16'h0000
`define APC_RST_SMOOTH 16'h012c
`define APC_RST_MAXREV 16'h0001
// Input function codes
`define APC_FN_LATCH 8'h0c
`define APC_FN_CLEAR 8'h0d
`define APC_FN_INHIBIT 8'h45
`define APC_INHIBIT_DI 7
`define APC_X_ENABLE 4'h1
// Arithmetic: 2^15 sample counts is +10 V, position has 8 fraction bits
`define APC_MAP_SHIFT 7
`define APC_SMOOTH_SHIFT 3
`define APC_SMOOTH_STEP_MAX 16'h0001
// Timing
`define APC_CLK_NS 25
`define APC_TICK_NS 100000
`endif

// ==== apc_pkg.sv ====
package apc_pkg;
  typedef enum logic [3:0] {
    APC_IDLE = 4'b0001,
    APC_TRACK = 4'b0010,
    APC_LATCH = 4'b0100,
    APC_CLEAR = 4'b1000
  } apc_state_t;
endpackage

// ==== apc_core.sv ====
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "apc_defs.svh"

// Summary of operation
// - Inhibit input discards step pulses in pulse mode
// - Analog positioning needs pulse mode and enable one
// - Enable zero ignores analog voltage for position
// - Servo-on takes motor position as zero volts
// - Smoothing applies to analog commands, bigger slower
// - Smoothing zero or one gives a step
// - Revolutions equal volts over ten times maximum
// - Latch input holds captured position while asserted
// - Latch release carries out pending analog change
// - Clear input holds present position while asserted
// - Clear release redefines position without motion
module apc_core #(
  parameter int DI_NUM = 8,
  parameter int TICK_CYCLES = `APC_TICK_NS / `APC_CLK_NS
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [DI_NUM-1:0] di_pin,
  input wire logic servo_on_pin,
  input wire logic step_pin,
  input wire logic dir_pin,
  input wire logic signed [15:0] adc_sample,
  input wire logic signed [31:0] motor_pos,
  output logic signed [31:0] pos_cmd,
  output logic analog_active,
  output logic pulses_blocked
);

  localparam int SW = DI_NUM + 3;

  // =====================================================
  // Helper functions
  // Any input mapped to a function code and active
  function automatic logic fn_hit(input logic [63:0] map, input logic [DI_NUM-1:0] di,
                                  input logic [7:0] code);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < DI_NUM; i++) begin
      if (map[i*8 +: 8] == code && di[i]) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  // Signed sample times max revolutions, in 1/256 revolution
  function automatic logic signed [31:0] rev_map(input logic signed [15:0] s, input logic [15:0] mx);
    logic signed [32:0] prod;
    prod = s * $signed({1'b0, mx});
    return 32'(prod >>> `APC_MAP_SHIFT);
  endfunction

  // =====================================================
  // Registers and state
  logic [15:0] cfg_q, smooth_q, maxrev_q, ctrl_q;
  logic [63:0] fmap_q;
  logic [SW-1:0] sync1_q, sync2_q, sync3_q, filt_q;
  logic step_prev_q;
  logic pready_q, pslverr_q;
  logic [31:0] prdata_q;
  apc_pkg::apc_state_t state_q;
  logic signed [31:0] ref_q, hold_q, pos_cmd_q;
  logic [11:0] tick_q;
  logic [15:0] div_q;
  logic active_q, blocked_q;

  // =====================================================
  // Input synchronisers
  logic [DI_NUM-1:0] di_f;
  logic son_f, step_f, dir_f;
  // Three stages; a change counts once stages two and three agree
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
      filt_q <= '0;
    end else if (clk_en) begin
      sync1_q <= {dir_pin, step_pin, servo_on_pin, di_pin};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      filt_q <= (sync2_q & sync3_q) | (filt_q & ~(sync2_q ^ sync3_q));
    end
  end

  assign di_f = filt_q[DI_NUM-1:0];
  assign son_f = filt_q[DI_NUM];
  assign step_f = filt_q[DI_NUM+1];
  assign dir_f = filt_q[DI_NUM+2];

  // =====================================================
  // Decoded controls
  logic pt_mode, analog_en, latch_on, clear_on, inhibit_on, step_edge;
  logic signed [31:0] target, diff, delta;
  logic step_now;
  assign pt_mode = ctrl_q[`APC_CTRL_PT_BIT];
  // Analog only in pulse mode with enable field one
  assign analog_en = pt_mode && cfg_q[`APC_CFG_X_LSB +: 4] == `APC_X_ENABLE;
  assign latch_on = fn_hit(fmap_q, di_f, `APC_FN_LATCH);
  assign clear_on = fn_hit(fmap_q, di_f, `APC_FN_CLEAR);
  // Only the eighth input may carry the inhibit function
  assign inhibit_on = fmap_q[`APC_INHIBIT_DI*8 +: 8] == `APC_FN_INHIBIT && di_f[`APC_INHIBIT_DI];
  assign step_edge = step_f && !step_prev_q;
  // Zero-volt reference plus mapped voltage
  assign target = ref_q + rev_map(adc_sample, maxrev_q);
  assign diff = target - pos_cmd_q;
  assign delta = diff >>> `APC_SMOOTH_SHIFT;
  assign step_now = tick_q == 12'(TICK_CYCLES - 1) && div_q >= smooth_q;

  // =====================================================
  // APB slave
  logic apb_acc;
  assign apb_acc = psel && penable && pready_q;
  // One wait state, then a single-cycle ready
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end else if (clk_en) begin
      pready_q <= psel && penable && !pready_q;
      pslverr_q <= 1'b0;
      if (psel && penable && !pready_q) begin
        prdata_q <= '0;
        unique case (paddr)
          `APC_OFF_CFG: prdata_q <= {16'h0000, cfg_q};
          `APC_OFF_SMOOTH: prdata_q <= {16'h0000, smooth_q};
          `APC_OFF_MAXREV: prdata_q <= {16'h0000, maxrev_q};
          `APC_OFF_CTRL: prdata_q <= {16'h0000, ctrl_q};
          `APC_OFF_FMAP_LO: prdata_q <= fmap_q[31:0];
          `APC_OFF_FMAP_HI: prdata_q <= fmap_q[63:32];
          `APC_OFF_STAT: prdata_q <= {24'h000000, blocked_q, active_q, son_f, inhibit_on, state_q};
          `APC_OFF_POS: prdata_q <= pos_cmd_q;
          default: pslverr_q <= 1'b1;
        endcase
      end
    end
  end

  // Register writes at the ready edge
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_q <= `APC_RST_CFG;
      smooth_q <= `APC_RST_SMOOTH;
      maxrev_q <= `APC_RST_MAXREV;
      ctrl_q <= '0;
      fmap_q <= '0;
    end else if (clk_en && apb_acc && pwrite) begin
      unique case (paddr)
        `APC_OFF_CFG: cfg_q <= pwdata[15:0];
        `APC_OFF_SMOOTH: smooth_q <= pwdata[15:0];
        `APC_OFF_MAXREV: maxrev_q <= pwdata[15:0];
        `APC_OFF_CTRL: ctrl_q <= pwdata[15:0];
        `APC_OFF_FMAP_LO: fmap_q[31:0] <= pwdata;
        `APC_OFF_FMAP_HI: fmap_q[63:32] <= pwdata;
        default: ;
      endcase
    end
  end

  // =====================================================
  // Smoothing timebase: a step every smooth_q + 1 ticks
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      tick_q <= '0;
      div_q <= '0;
    end else if (clk_en) begin
      if (state_q != apc_pkg::APC_TRACK) begin
        tick_q <= '0;
        div_q <= '0;
      end else if (tick_q == 12'(TICK_CYCLES - 1)) begin
        tick_q <= '0;
        div_q <= (div_q >= smooth_q) ? 16'h0000 : div_q + 16'h0001;
      end else begin
        tick_q <= tick_q + 12'h001;
      end
    end
  end

  // =====================================================
  // Analog position sequencer
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= apc_pkg::APC_IDLE;
      ref_q <= '0;
      hold_q <= '0;
    end else if (clk_en) begin
      unique case (state_q)
        apc_pkg::APC_IDLE: begin
          if (analog_en && son_f) begin
            ref_q <= motor_pos;
            state_q <= apc_pkg::APC_TRACK;
          end
        end
        apc_pkg::APC_TRACK: begin
          if (!(analog_en && son_f)) begin
            state_q <= apc_pkg::APC_IDLE;
          end else if (clear_on) begin
            hold_q <= motor_pos;
            state_q <= apc_pkg::APC_CLEAR;
          end else if (latch_on) begin
            hold_q <= motor_pos;
            state_q <= apc_pkg::APC_LATCH;
          end
        end
        apc_pkg::APC_LATCH: begin
          if (!(analog_en && son_f)) begin
            state_q <= apc_pkg::APC_IDLE;
          end else if (!latch_on) begin
            state_q <= apc_pkg::APC_TRACK;
          end
        end
        apc_pkg::APC_CLEAR: begin
          if (!(analog_en && son_f)) begin
            state_q <= apc_pkg::APC_IDLE;
          end else if (!clear_on) begin
            ref_q <= motor_pos - rev_map(adc_sample, maxrev_q);
            state_q <= apc_pkg::APC_TRACK;
          end
        end
        default: state_q <= apc_pkg::APC_IDLE;
      endcase
    end
  end

  // =====================================================
  // Position command: pulse counting or smoothed analog
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pos_cmd_q <= '0;
      step_prev_q <= 1'b0;
      blocked_q <= 1'b0;
      active_q <= 1'b0;
    end else if (clk_en) begin
      step_prev_q <= step_f;
      active_q <= state_q != apc_pkg::APC_IDLE;
      blocked_q <= pt_mode && inhibit_on;
      unique case (state_q)
        apc_pkg::APC_IDLE: begin
          if (analog_en && son_f) begin
            pos_cmd_q <= motor_pos;
          end else if (pt_mode && son_f && step_edge && !inhibit_on) begin
            pos_cmd_q <= dir_f ? pos_cmd_q - 32'sd1 : pos_cmd_q + 32'sd1;
          end
        end
        apc_pkg::APC_TRACK: begin
          if (clear_on || latch_on) begin
            pos_cmd_q <= motor_pos;
          end else if (smooth_q <= `APC_SMOOTH_STEP_MAX) begin
            pos_cmd_q <= target;
          end else if (step_now) begin
            pos_cmd_q <= (delta == 0) ? target : pos_cmd_q + delta;
          end
        end
        apc_pkg::APC_LATCH: pos_cmd_q <= hold_q;
        apc_pkg::APC_CLEAR: pos_cmd_q <= clear_on ? hold_q : motor_pos;
        default: pos_cmd_q <= pos_cmd_q;
      endcase
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign pos_cmd = pos_cmd_q;
  assign analog_active = active_q;
  assign pulses_blocked = blocked_q;

  // =====================================================
  // Assertions
  default clocking apc_cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  AST_INHIBIT_DROP: assert property (
    clk_en && state_q == apc_pkg::APC_IDLE && !analog_en && step_edge && inhibit_on |=> $stable(pos_cmd_q))
    else $error("Inhibited pulse moved the command");

  AST_DI8_ONLY: assert property (
    clk_en && fmap_q[`APC_INHIBIT_DI*8 +: 8] != `APC_FN_INHIBIT |-> !inhibit_on)
    else $error("Inhibit honoured on a wrong input");

  AST_ANALOG_GATE: assert property (
    clk_en && state_q == apc_pkg::APC_IDLE && analog_en && son_f |=> state_q == apc_pkg::APC_TRACK)
    else $error("Analog mode not entered");

  AST_ANALOG_OFF: assert property (
    clk_en && !analog_en |=> state_q == apc_pkg::APC_IDLE ##1 !analog_active)
    else $error("Analog mode active while disabled");

  AST_SERVO_REF: assert property (
    clk_en && state_q == apc_pkg::APC_IDLE && analog_en && son_f |=> ref_q == $past(motor_pos))
    else $error("Zero-volt reference not captured");

  AST_STEP: assert property (
    clk_en && state_q == apc_pkg::APC_TRACK && analog_en && son_f && !latch_on && !clear_on
    && smooth_q <= `APC_SMOOTH_STEP_MAX |=> pos_cmd_q == $past(target))
    else $error("Step command not applied");

  AST_SMOOTH_WAIT: assert property (
    clk_en && state_q == apc_pkg::APC_TRACK && !latch_on && !clear_on
    && smooth_q > `APC_SMOOTH_STEP_MAX && !step_now |=> $stable(pos_cmd_q))
    else $error("Command moved between smoothing steps");

  AST_LATCH_HOLD: assert property (
    state_q == apc_pkg::APC_LATCH && $past(state_q) == apc_pkg::APC_LATCH && $past(clk_en)
    |-> pos_cmd_q == hold_q)
    else $error("Latched position not held");

  AST_CLEAR_REDEF: assert property (
    clk_en && state_q == apc_pkg::APC_CLEAR && analog_en && son_f && !clear_on
    |=> state_q == apc_pkg::APC_TRACK && pos_cmd_q == $past(motor_pos)
    && ref_q + $past(target - ref_q) == $past(motor_pos))
    else $error("Clear release did not redefine position");

  AST_APB_READY: assert property (
    clk_en && psel && penable && !pready_q |=> pready_q ##1 !pready_q)
    else $error("APB ready not a single cycle");

  AST_CLEAR_HOLD: assert property (
    state_q == apc_pkg::APC_CLEAR && $past(state_q) == apc_pkg::APC_CLEAR && $past(clk_en) && $past(clear_on)
    |-> pos_cmd_q == hold_q)
    else $error("Cleared position not held");

  AST_FREEZE: assert property (
    !clk_en |=> $stable(pos_cmd_q) && $stable(state_q))
    else $error("State moved while clock enable low");

endmodule
`default_nettype wire

// ==== apc_motor_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========
// Motor position loop model
module apc_motor_model #(
  parameter int INIT_POS = 32'h1000
) (
  input wire logic core_clk,
  input wire logic follow,
  input wire logic slow,
  input wire logic signed [31:0] pos_cmd,
  output logic signed [31:0] motor_pos
);
  logic signed [31:0] err;
  assign err = pos_cmd - motor_pos;
  // Track the command at once, or rate limited when slow
  initial motor_pos = INIT_POS;
  always @(posedge core_clk) begin
    if (follow && !slow) begin
      motor_pos <= pos_cmd;
    end else if (follow) begin
      motor_pos <= motor_pos + ((err > 16) ? 16 : (err < -16) ? -16 : err);
    end
  end
endmodule
`default_nettype wire

// ==== test_analog_position_command_unit.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========
// Bench top
module test_analog_position_command_unit;
  logic core_clk, reset_n, clk_en, psel, penable, pwrite, pready, pslverr, servo_on_pin, step_pin, dir_pin;
  logic analog_active, pulses_blocked, slow, err;
  logic [7:0] paddr, di_pin;
  logic [15:0] m;
  logic [31:0] pwdata, prdata, rd, lf;
  logic signed [15:0] adc_sample, a0;
  logic signed [31:0] motor_pos, pos_cmd, ref_pos, p0, t;
  int bad_count, num_checks, cyc;
  apc_core #(.TICK_CYCLES(4)) dut_u (.core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .di_pin(di_pin), .servo_on_pin(servo_on_pin), .step_pin(step_pin), .dir_pin(dir_pin),
    .adc_sample(adc_sample), .motor_pos(motor_pos), .pos_cmd(pos_cmd), .analog_active(analog_active),
    .pulses_blocked(pulses_blocked));
  apc_motor_model motor_u (.core_clk(core_clk), .follow(analog_active), .slow(slow), .pos_cmd(pos_cmd),
    .motor_pos(motor_pos));
  // Clock and timeout
  initial begin
    core_clk = 0;
    forever #12.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      complete_run();
    end
  end
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
  endfunction
  // Analog target in 1/256 rev
  function automatic logic signed [31:0] tgt(input logic signed [31:0] r, input logic signed [15:0] a,
    input logic [15:0] mr);
    return r + ((int'(a) * int'(mr)) >>> 7);
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks=%0d errors=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic rst();
    reset_n <= 0;
    repeat (8) @(posedge core_clk);
    reset_n <= 1;
  endtask
  // APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1;
    // Ends when pready is seen high; only the bench timeout ends it if pready never rises
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge core_clk);
  endtask
  task automatic wait_pos(input logic [31:0] e);
    int n;
    n = 0;
    while (pos_cmd !== e && n < 20000) begin
      @(posedge core_clk);
      n++;
    end
    check(pos_cmd, e);
  endtask
  task automatic steps(input int n);
    repeat (n) begin
      step_pin <= 1;
      repeat (8) @(posedge core_clk);
      step_pin <= 0;
      repeat (8) @(posedge core_clk);
    end
  endtask
  // ==========
  // Main sequence
  initial begin
    {psel, penable, pwrite, servo_on_pin, step_pin, dir_pin, slow} = 0;
    clk_en = 1;
    reset_n = 0;
    paddr = 0;
    pwdata = 0;
    di_pin = 0;
    adc_sample = 0;
    cyc = 0;
    lf = 32'h77f1;
    @(posedge core_clk);
    rst();
    apb(0, 8'h00, 0); check(rd, 32'h0);
    apb(0, 8'h04, 0); check(rd, 32'h12c);
    apb(0, 8'h08, 0); check(rd, 32'h1);
    apb(0, 8'h20, 0); check(err, 1'b1);
    // Enable without pulse mode stays idle
    lf = nxt(lf);
    m = 16'(1 + lf % 30);
    apb(1, 8'h08, m);
    apb(1, 8'h04, 0);
    apb(1, 8'h00, 1);
    servo_on_pin <= 1;
    repeat (20) @(posedge core_clk);
    check(analog_active, 1'b0);
    servo_on_pin <= 0;
    repeat (20) @(posedge core_clk);
    apb(1, 8'h0c, 1);
    lf = nxt(lf);
    adc_sample <= lf[15:0];
    ref_pos = motor_pos;
    servo_on_pin <= 1;
    wait_pos(tgt(ref_pos, lf[15:0], m));
    check(analog_active, 1'b1);
    adc_sample <= 16'sh8000;
    wait_pos(ref_pos - m * 256);
    // Slow smoothing approaches gradually
    apb(1, 8'h04, 2);
    lf = nxt(lf);
    adc_sample <= lf[15:0];
    t = tgt(ref_pos, lf[15:0], m);
    repeat (6) @(posedge core_clk);
    check(pos_cmd !== t, 1'b1);
    wait_pos(t);
    apb(1, 8'h04, 0);
    // Latch holds, release catches up
    apb(1, 8'h10, 32'h000d_0c00);
    p0 = pos_cmd;
    di_pin[1] <= 1;
    repeat (10) @(posedge core_clk);
    lf = nxt(lf);
    adc_sample <= lf[15:0];
    repeat (30) @(posedge core_clk);
    check(pos_cmd, p0);
    di_pin[1] <= 0;
    wait_pos(tgt(ref_pos, lf[15:0], m));
    // Clear holds, release redefines without motion
    a0 = adc_sample;
    slow <= 1;
    di_pin[2] <= 1;
    repeat (10) @(posedge core_clk);
    lf = nxt(lf);
    adc_sample <= lf[15:0];
    repeat (300) @(posedge core_clk);
    p0 = motor_pos;
    check(pos_cmd, p0);
    di_pin[2] <= 0;
    repeat (30) @(posedge core_clk);
    check(pos_cmd, p0);
    slow <= 0;
    adc_sample <= a0;
    wait_pos(tgt(p0 - tgt(0, lf[15:0], m), a0, m));
    // Pulse mode with analog disabled
    rst();
    apb(1, 8'h0c, 1);
    lf = nxt(lf);
    adc_sample <= lf[15:0];
    p0 = pos_cmd;
    steps(5);
    wait_pos(p0 + 5);
    check(analog_active, 1'b0);
    dir_pin <= 1;
    steps(2);
    wait_pos(p0 + 3);
    dir_pin <= 0;
    // Inhibit on the eighth input blocks steps
    apb(1, 8'h14, 32'h4500_0000);
    di_pin[7] <= 1;
    repeat (20) @(posedge core_clk);
    check(pulses_blocked, 1'b1);
    steps(3);
    repeat (20) @(posedge core_clk);
    check(pos_cmd, p0 + 3);
    // Inhibit mapped elsewhere is not honoured
    apb(1, 8'h14, 0);
    apb(1, 8'h10, 32'h45);
    di_pin <= 8'h01;
    repeat (20) @(posedge core_clk);
    check(pulses_blocked, 1'b0);
    steps(2);
    wait_pos(p0 + 5);
    // Clock enable low freezes the pulse counter
    clk_en <= 0;
    steps(2);
    clk_en <= 1;
    repeat (20) @(posedge core_clk);
    check(pos_cmd, p0 + 5);
    complete_run();
  end
endmodule
`default_nettype wire
